// ---- flash_prot_pkg.sv ----
// shared constants and types for the flash sector protection control block
package flash_prot_pkg;

	// serial pins arriving from the host, all taken as synchronous to ref_clk_in
	typedef struct packed {
		logic cs_n; // chip select, active low
		logic sck;  // serial clock from the host
		logic si;   // serial data into the device
	} spi_pins_s;

	// geometry
	localparam int NUM_SECTORS = 16;
	localparam int SECT_W = 4;
	localparam int SECT_SEL_LSB = 0;   // sector number sits in the low nibble of address byte 0
	localparam int ADDR_LAST = 2;      // index of the last of three address bytes

	// opcodes
	localparam logic [7:0] OPC_RD_PROT = 8'h3C; // read one sector's protection flag
	localparam logic [7:0] OPC_WR_STAT = 8'h01; // write status register

	// written status byte layout
	localparam int WR_LOCK_POS = 7;    // the only stored bit
	localparam int WR_GP_HI = 5;       // global decode field, upper bit
	localparam int WR_GP_LO = 2;       // global decode field, lower bit
	localparam logic [3:0] GP_UNPROTECT = 4'h0;
	localparam logic [3:0] GP_PROTECT = 4'hF;

	// read-back status byte layout
	localparam int ST_LOCK_POS = 7;
	localparam int ST_WPP_POS = 4;     // write-protect pin level
	localparam int ST_SUM_HI = 3;
	localparam int ST_SUM_LO = 2;

	// protection summary codes
	localparam logic [1:0] SUM_NONE = 2'h0;
	localparam logic [1:0] SUM_SOME = 2'h1;
	localparam logic [1:0] SUM_ALL = 2'h3;

	// reset values
	localparam logic [NUM_SECTORS-1:0] SECTOR_RST = 16'hFFFF; // power up all protected
	localparam logic LOCK_RST = 1'b0;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// command decoder states
	typedef enum logic [2:0] {
		ST_OPCODE,
		ST_ADDR,
		ST_WRSTAT,
		ST_RDPROT,
		ST_IGNORE
	} cmd_state_e;

endpackage : flash_prot_pkg

// ---- flash_sector_protect_control.sv ----
// sector protection control: global protect decode, lock bit and protection query
// Notes on behaviour
// - unlocked write with field 0000 unprotects all
// - unlocked write with field 1111 protects all
// - other field patterns leave flags; lock follows
// - lock set, pin high: no global action
// - lock set, pin high: lock follows bit 7
// - 00h unprotects, 7Fh protects, FFh protects+locks
// - 0Fh clears lock only, F0h sets only
// - only bit 7 stored; field reads report state
// - query returns protection flag, never pin state
// - query streams FFh protected, 00h unprotected
// - chip select high ends query, output floats
// - summary tells all, some or no sectors protected
// - pin low and lock set: everything frozen
module flash_sector_protect_control
	import flash_prot_pkg::*;
(
	// clock and reset
	input wire logic ref_clk_in,
	input wire logic srst_in,
	// serial link from the host
	input wire spi_pins_s spi_in,
	input wire logic wp_n_in,
	// serial output, enable low while driving
	output logic so_out,
	output logic so_oe_n_out,
	// protection state
	output logic protection_lock_bit_out,
	output logic [NUM_SECTORS-1:0] sector_prot_out,
	output logic [1:0] soft_protect_summary_out,
	output logic [7:0] status_out
);

	// state held from one edge to the next
	cmd_state_e state_q; // command decoder state
	logic sck_q; // previous sck level for edge detection
	logic [7:0] shift_q; // incoming byte, msb first
	logic [2:0] bit_q; // bit index within current byte
	logic [1:0] byte_q; // address byte index
	logic [SECT_W-1:0] sect_q; // sector named by the query address
	logic lock_q; // protection lock bit
	logic [NUM_SECTORS-1:0] prot_q; // per-sector protection flags

	// combinational helpers
	logic sck_rise; // device sampling edge
	logic sck_fall; // device launch edge
	logic byte_done; // eighth bit of a byte taken this cycle
	logic [7:0] byte_d; // completed byte including the bit taken now
	logic wr_go; // status write byte completes this cycle
	logic [3:0] gp_field; // written global decode field
	logic hard_locked; // pin asserted and lock set
	logic prot_all; // every sector protected
	logic prot_none; // no sector protected

	// edge detection on the sampled host clock
	// sck is oversampled, so the host must hold each level for at least one cycle
	assign sck_rise = spi_in.sck & ~sck_q;
	assign sck_fall = ~spi_in.sck & sck_q;
	assign byte_done = ~spi_in.cs_n & sck_rise & (bit_q == BIT_LAST);
	assign byte_d = {shift_q[6:0], spi_in.si};
	assign wr_go = byte_done & (state_q == ST_WRSTAT);
	assign gp_field = byte_d[WR_GP_HI:WR_GP_LO];
	assign hard_locked = ~wp_n_in & lock_q;
	assign prot_all = &prot_q;
	assign prot_none = ~|prot_q;

	// track the host clock level
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			sck_q <= 1'b0;
		end else begin
			sck_q <= spi_in.sck;
		end
	end

	// bit shifter and bit counter; restart whenever chip select is high
	// a cut byte is simply dropped, so a partial write never takes effect
	always_ff @(posedge ref_clk_in) begin
		if (srst_in || spi_in.cs_n) begin
			shift_q <= 8'h00;
			bit_q <= 3'h0;
		end else if (sck_rise) begin
			shift_q <= byte_d;
			bit_q <= bit_q + 3'h1;
		end
	end

	// command decoder
	// opcode first, then either one status byte or three address bytes
	always_ff @(posedge ref_clk_in) begin
		if (srst_in || spi_in.cs_n) begin
			// a raised chip select abandons any command, even mid-byte
			state_q <= ST_OPCODE;
			byte_q <= 2'h0;
		end else if (byte_done) begin
			unique case (state_q)
				ST_OPCODE: begin
					if (byte_d == OPC_RD_PROT) begin
						state_q <= ST_ADDR;
					end else if (byte_d == OPC_WR_STAT) begin
						state_q <= ST_WRSTAT;
					end else begin
						// opcodes outside this block are left to other logic
						state_q <= ST_IGNORE;
					end
				end
				ST_ADDR: begin
					if (byte_q == 2'(ADDR_LAST)) begin
						state_q <= ST_RDPROT;
					end
					byte_q <= byte_q + 2'h1;
				end
				ST_WRSTAT: begin
					// one byte only; extra clocks are ignored
					state_q <= ST_IGNORE;
				end
				ST_RDPROT: begin
					state_q <= ST_RDPROT; // stream repeats until chip select rises
				end
				ST_IGNORE: begin
					state_q <= ST_IGNORE;
				end
			endcase
		end
	end

	// sector select: low nibble of the first address byte, the top address
	// bits that the sixteen sectors span; the other two bytes only pad
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			sect_q <= '0;
		end else if (byte_done && state_q == ST_ADDR && byte_q == 2'h0) begin
			sect_q <= byte_d[SECT_SEL_LSB +: SECT_W];
		end
	end

	// lock bit: only bit 7 of a status write is stored
	// with the pin low and the lock clear the bit may still be set
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			lock_q <= LOCK_RST;
		end else if (wr_go && !hard_locked) begin
			// hard lock freezes the bit; otherwise it follows the write
			lock_q <= byte_d[WR_LOCK_POS];
		end
	end

	// global protect and unprotect decode
	// soft and hard lock both block it, since either needs the lock set
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			prot_q <= SECTOR_RST;
		end else if (wr_go && !lock_q) begin
			// decision uses the lock value before this write, so clearing
			// the lock and a global action can never share one write
			if (gp_field == GP_UNPROTECT) begin
				prot_q <= '0;
			end else if (gp_field == GP_PROTECT) begin
				prot_q <= '1;
			end
			// any other pattern leaves the flags alone
		end
	end

	// serial output: launched on falling edges, floats with chip select high
	// only the flag is sent, so the pin level can never leak into the stream
	always_ff @(posedge ref_clk_in) begin
		if (srst_in || spi_in.cs_n) begin
			so_out <= 1'b0;
			so_oe_n_out <= 1'b1;
		end else if (state_q == ST_RDPROT && sck_fall) begin
			// every bit of the repeating byte equals the flag: FFh or 00h
			so_out <= prot_q[sect_q];
			so_oe_n_out <= 1'b0;
		end
	end

	// registered views of protection state and the status byte
	// one cycle behind the state, which keeps every output on a flip-flop
	always_ff @(posedge ref_clk_in) begin
		if (srst_in) begin
			protection_lock_bit_out <= LOCK_RST;
			sector_prot_out <= SECTOR_RST;
			soft_protect_summary_out <= SUM_ALL;
			status_out <= 8'h00;
		end else begin
			protection_lock_bit_out <= lock_q;
			sector_prot_out <= prot_q;
			if (prot_all) begin
				soft_protect_summary_out <= SUM_ALL;
			end else if (prot_none) begin
				soft_protect_summary_out <= SUM_NONE;
			end else begin
				soft_protect_summary_out <= SUM_SOME;
			end
			// field positions report pin and protection, never written data
			status_out <= 8'h00;
			status_out[ST_LOCK_POS] <= lock_q;
			status_out[ST_WPP_POS] <= wp_n_in;
			status_out[ST_SUM_HI:ST_SUM_LO] <= prot_all ? SUM_ALL :
				(prot_none ? SUM_NONE : SUM_SOME);
		end
	end

	// checks kept beside the logic
	// most properties are held off while reset is asserted

	// flags first, then their registered copy one cycle later
	AST_GLOBAL_UNPROT: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		wr_go && !lock_q && gp_field == GP_UNPROTECT |=> prot_q == '0 ##1 sector_prot_out == '0)
		else $error("global unprotect did not clear all flags");

	AST_GLOBAL_PROT: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		wr_go && !lock_q && gp_field == GP_PROTECT |=> prot_q == '1 ##1 sector_prot_out == '1)
		else $error("global protect did not set all flags");

	AST_PARTIAL_KEEP: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		wr_go && !lock_q && gp_field != GP_PROTECT && gp_field != GP_UNPROTECT
		|=> $stable(prot_q))
		else $error("partial field pattern changed protection flags");

	// pin high and lock set: the flags must not move
	AST_SOFT_LOCK: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		wr_go && lock_q && wp_n_in |=> $stable(prot_q))
		else $error("global action taken while soft locked");

	AST_SOFT_UNLOCK: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		wr_go && lock_q && wp_n_in |=> lock_q == $past(byte_d[WR_LOCK_POS]))
		else $error("soft locked write did not update lock bit");

	AST_LOCK_FOLLOWS: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		wr_go && !lock_q |=> lock_q == $past(byte_d[WR_LOCK_POS])
		##1 protection_lock_bit_out == lock_q)
		else $error("lock bit did not follow written bit 7");

	// pin low and lock set: neither the lock nor the flags may change
	AST_HARD_LOCK: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		wr_go && lock_q && !wp_n_in |=> $stable(lock_q) && $stable(prot_q))
		else $error("hard lock state changed by status write");

	AST_FLOAT: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		spi_in.cs_n |=> so_oe_n_out && state_q == ST_OPCODE)
		else $error("serial output not floated after chip select rose");

	// prot_q held steady so the expected bit is well defined
	AST_QUERY_DATA: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		state_q == ST_RDPROT && sck_fall && !spi_in.cs_n && $stable(prot_q)
		|=> !so_oe_n_out && so_out == prot_q[sect_q])
		else $error("protection query bit wrong");

	AST_SUMMARY: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		prot_none && $stable(prot_q) |=> soft_protect_summary_out == SUM_NONE
		&& status_out[ST_SUM_HI:ST_SUM_LO] == SUM_NONE)
		else $error("summary does not show no sectors protected");

	// all sectors protected must read back as the all code
	AST_SUMMARY_ALL: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		prot_all |=> soft_protect_summary_out == SUM_ALL
		&& status_out[ST_SUM_HI:ST_SUM_LO] == SUM_ALL)
		else $error("summary does not show all sectors protected");

	// reset always leaves the lock clear, inside and at the pin
	AST_LOCK_RESET: assert property (@(posedge ref_clk_in)
		srst_in |=> !lock_q && !protection_lock_bit_out)
		else $error("lock bit not cleared by reset");

	// a streamed bit stands until the next falling host clock
	AST_QUERY_HOLD: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		state_q == ST_RDPROT && !spi_in.cs_n && !sck_fall
		|=> $stable(so_out) && $stable(so_oe_n_out))
		else $error("query output moved between falling edges");

	// the pin is driven only inside a protection query
	AST_DRIVE_IN_QUERY: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		!so_oe_n_out |-> state_q == ST_RDPROT)
		else $error("serial output driven outside a protection query");

	// the named sector cannot move while its flag streams out
	AST_SECTOR_HOLD: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		state_q == ST_RDPROT |=> $stable(sect_q))
		else $error("query sector changed during the read");

	// registered copies trail the state by exactly one cycle
	AST_VIEW_MIRROR: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		!srst_in |=> sector_prot_out == $past(prot_q)
		&& protection_lock_bit_out == $past(lock_q))
		else $error("registered protection view out of step");

	// status view reports the pin and the lock, never written bits
	AST_STATUS_VIEW: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		!srst_in |=> status_out[ST_WPP_POS] == $past(wp_n_in)
		&& status_out[ST_LOCK_POS] == $past(lock_q))
		else $error("status view does not show pin and lock");

	// bytes after the single status byte change nothing
	AST_EXTRA_IGNORED: assert property (@(posedge ref_clk_in) disable iff (srst_in)
		state_q == ST_IGNORE |=> $stable(lock_q) && $stable(prot_q))
		else $error("byte after status write changed protection state");

endmodule : flash_sector_protect_control

// ---- spi_host_model.sv ----
// host serial controller model that drives the protection block
module spi_host_model
	import flash_prot_pkg::*;
(
	// clock and returned data
	input wire logic clk_in,
	input wire logic so_in,
	input wire logic so_oe_n_in,
	// pins toward the device
	output spi_pins_s spi_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic so_line; // level seen on the wire
	// a floated line reads the inverse of so_in, which is 0 while floated
	assign so_line = so_oe_n_in ? ~so_in : so_in;
	initial spi_out = '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
	// pins move only at falling edges of the system clock
	task automatic tick(input int n);
		repeat (n) @(negedge clk_in);
	endtask : tick
	// select the device
	task automatic start();
		spi_out.cs_n = 1'b0;
		tick(1);
	endtask : start
	// deselect, any time, even mid-byte
	task automatic stop();
		spi_out.cs_n = 1'b1;
		tick(3);
	endtask : stop
	// msb first, sck high two cycles and low five, read back three cycles after the fall
	task automatic shift(input logic [7:0] tx, input int nbits, output logic [7:0] rx);
		rx = 8'h00;
		for (int i = 7; i > 7 - nbits; i--) begin
			spi_out.si = tx[i];
			tick(2);
			spi_out.sck = 1'b1;
			tick(2);
			spi_out.sck = 1'b0;
			tick(3);
			rx[i] = so_line;
		end
	endtask : shift
endmodule : spi_host_model

// ---- tb_flash_sector_protect_control.sv ----
// self-checking bench for the sector protection control block
module tb_flash_sector_protect_control
	import flash_prot_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic ref_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic wp_n_in = 1'b1;
	spi_pins_s spi; // driven by the host model
	logic so_out;
	logic so_oe_n_out;
	logic lock;
	logic [15:0] prot;
	logic [1:0] sum;
	logic [7:0] status;
	logic [7:0] rx;
	int n_mismatch = 0;
	int tests_run = 0;
	// write table: data, pin level, expected lock, expected all-flag value
	logic [7:0] wr_d [12] = '{8'h00, 8'h7F, 8'h00, 8'h84, 8'h7F, 8'h7F, 8'hF0, 8'h0F,
		8'hFF, 8'h00, 8'h00, 8'h00};
	// one bit per write, entry 0 the leftmost digit
	logic [0:11] wr_wp = 12'hFFB;
	logic [0:11] wr_lk = 12'h12C;
	logic [0:11] wr_pr = 12'h47E;
	always #5 ref_clk_in = ~ref_clk_in;
	flash_sector_protect_control u_flash_sector_protect_control (
		.ref_clk_in(ref_clk_in), .srst_in(srst_in), .spi_in(spi), .wp_n_in(wp_n_in),
		.so_out(so_out), .so_oe_n_out(so_oe_n_out), .protection_lock_bit_out(lock),
		.sector_prot_out(prot), .soft_protect_summary_out(sum), .status_out(status));
	spi_host_model u_spi_host_model (
		.clk_in(ref_clk_in), .so_in(so_out), .so_oe_n_in(so_oe_n_out), .spi_out(spi));
	// one comparison, four-state exact
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// counts, verdict, end of run
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : summarize
	// lock, flags, summary and status view against expectation
	task automatic check_state(input logic exp_lk, input logic [15:0] exp_pr);
		logic [1:0] es;
		es = (exp_pr == 16'h0000) ? SUM_NONE : (exp_pr == 16'hFFFF) ? SUM_ALL : SUM_SOME;
		chk("lock", {15'h0, exp_lk}, {15'h0, lock});
		chk("flags", exp_pr, prot);
		chk("summary", {14'h0, es}, {14'h0, sum});
		chk("status", {8'h00, exp_lk, 2'h0, wp_n_in, es, 2'h0}, {8'h00, status});
	endtask : check_state
	// opcode then one data byte
	task automatic wr_status(input logic [7:0] d);
		u_spi_host_model.start();
		u_spi_host_model.shift(OPC_WR_STAT, 8, rx);
		u_spi_host_model.shift(d, 8, rx);
		u_spi_host_model.stop();
	endtask : wr_status
	// query one sector, read two bytes, then abort inside a third
	task automatic query(input logic [3:0] sect, input logic [7:0] exp);
		u_spi_host_model.start();
		u_spi_host_model.shift(OPC_RD_PROT, 8, rx);
		u_spi_host_model.shift({4'h0, sect}, 8, rx);
		u_spi_host_model.shift(8'h5A, 8, rx);
		u_spi_host_model.shift(8'hA5, 8, rx);
		repeat (2) begin
			u_spi_host_model.shift(8'h00, 8, rx);
			chk("query byte", {8'h00, exp}, {8'h00, rx});
		end
		u_spi_host_model.shift(8'h00, 3, rx);
		chk("output enable mid-byte", 16'h0000, {15'h0, so_oe_n_out});
		u_spi_host_model.stop();
		chk("output enable after deselect", 16'h0001, {15'h0, so_oe_n_out});
	endtask : query
	// a hang is cut short here
	initial begin
		repeat (50000) @(posedge ref_clk_in);
		n_mismatch++;
		summarize();
	end
	// main sequence
	initial begin
		repeat (16) @(negedge ref_clk_in);
		srst_in = 1'b0;
		repeat (3) @(negedge ref_clk_in);
		check_state(1'b0, 16'hFFFF);
		$display("test reset done");
		for (int i = 0; i < 12; i++) begin
			wp_n_in = wr_wp[i];
			wr_status(wr_d[i]);
			check_state(wr_lk[i], {16{wr_pr[i]}});
		end
		$display("test status writes done");
		query(4'h3, 8'h00);
		wr_status(8'h7F);
		wp_n_in = 1'b0;
		query(4'hA, 8'hFF);
		$display("test protection query done");
		summarize();
	end
endmodule : tb_flash_sector_protect_control
